// ---- hw/gate_timer.v ----
// Measurement gate divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module gate_timer #(
   parameter CYCLES = 200000000
) (
   input wire i_clk,      // System clock
   input wire i_rst,      // Async reset, active high
   output reg o_gate      // One-cycle pulse at end of each gate
);
   reg [27:0] count;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count <= 28'h0000000;
         o_gate <= 1'b0;
      end else if (count == CYCLES[27:0] - 28'h0000001) begin
         count <= 28'h0000000;
         o_gate <= 1'b1;
      end else begin
         count <= count + 28'h0000001;
         o_gate <= 1'b0;
      end
   end
endmodule

// ---- hw/pulse_rate_meter.v ----
// One sensor channel: synchroniser, edge detect, rising-edge rate counter
`timescale 1ns/1ps
module pulse_rate_meter (
   input wire i_clk,          // System clock
   input wire i_rst,          // Async reset, active high
   input wire i_sensor,       // Raw sensor level
   input wire i_gate,         // End-of-gate pulse
   output reg [15:0] o_rate,  // Rising edges in last gate
   output wire o_level,       // Synchronised level
   output wire o_rise,        // Rising edge pulse
   output wire o_edge         // Any edge pulse
);
   reg meta;
   reg sync;
   reg prev;
   reg [15:0] count;
   reg [2:0] fill;
   wire primed;

   // Edges held off until prev holds a real sample, so a sensor that is
   // high through reset is not taken as a first rise
   assign primed = fill[2];
   assign o_level = sync;
   assign o_rise = sync & ~prev & primed;
   assign o_edge = (sync ^ prev) & primed;

   // ==========================================================================
   // Synchroniser and counter
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
         count <= 16'h0000;
         o_rate <= 16'h0000;
         fill <= 3'h0;
      end else begin
         fill <= {fill[1:0], 1'b1};
         meta <= i_sensor;
         sync <= meta;
         prev <= sync;
         if (i_gate) begin
            o_rate <= count;
            count <= {15'h0000, o_rise};
         end else if (o_rise && count != 16'hffff) begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule

// ---- hw/standstill_monitor_block.v ----
// Dual-sensor standstill monitor with restart modes and APB registers
`timescale 1ns/1ps
`include "standstill_regs.vh"

module standstill_monitor_block #(
   parameter GATE_CYCLES = `GATE_CYCLES
) (
   input wire I_CLK,              // 200 MHz clock
   input wire I_SYS_RST,          // Async reset, active high
   input wire I_SENSOR_A,         // First proximity sensor
   input wire I_SENSOR_B,         // Second proximity sensor
   input wire I_SAFETY_ACT,       // Safety activation
   input wire I_RESTART_RST,      // Restart reset
   input wire I_BLOCK_EN,         // External block enable
   input wire I_PSEL,             // APB select
   input wire I_PENABLE,          // APB enable
   input wire I_PWRITE,           // APB direction
   input wire [11:0] I_PADDR,     // APB address
   input wire [31:0] I_PWDATA,    // APB write data
   output reg O_PREADY,           // APB ready
   output reg [31:0] O_PRDATA,    // APB read data
   output reg O_PSLVERR,          // APB error
   output reg O_STANDSTILL,       // Standstill enable contact
   output reg O_FAULT,            // Fault contact
   output reg [15:0] O_FREQ,      // Actual frequency in Hz
   output reg [15:0] O_DIAG       // Diagnostic word
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_WAIT_SA = 3'h1;
   localparam [2:0] ST_RE_RISE = 3'h2;
   localparam [2:0] ST_RE_FALL = 3'h3;
   localparam [2:0] ST_MEASURE = 3'h4;
   localparam [2:0] ST_STILL = 3'h5;
   localparam [2:0] ST_FAULT = 3'h6;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [15:0] err_code;
   reg [15:0] next_err_code;
   reg ext_en_req;
   reg [1:0] mode;
   reg [5:0] threshold;
   reg first_edge;
   reg tripped;
   reg next_tripped;
   reg gate_d;
   reg sa_prev;
   reg re_prev;
   reg [15:0] gate_err;
   reg still_ok;
   reg [5:0] wr_thr;

   wire gate;
   wire [15:0] rate_a;
   wire [15:0] rate_b;
   wire level_a;
   wire level_b;
   wire rise_a;
   wire rise_b;
   wire edge_a;
   wire edge_b;
   wire active;
   wire sa_rise;
   wire re_rise;
   wire re_fall;
   wire sync_fault;
   wire [15:0] rate_diff;
   wire [21:0] hyst_lhs;
   wire [21:0] hyst_rhs;
   wire apb_write;
   wire apb_setup;

   // ==========================================================================
   // Sensor channels and gate
   gate_timer #(.CYCLES(GATE_CYCLES)) u_gate (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .o_gate(gate)
   );

   pulse_rate_meter u_chan_a (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_sensor(I_SENSOR_A),
      .i_gate(gate),
      .o_rate(rate_a),
      .o_level(level_a),
      .o_rise(rise_a),
      .o_edge(edge_a)
   );

   pulse_rate_meter u_chan_b (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_sensor(I_SENSOR_B),
      .i_gate(gate),
      .o_rate(rate_b),
      .o_level(level_b),
      .o_rise(rise_b),
      .o_edge(edge_b)
   );

   // ==========================================================================
   // Derived conditions
   assign active = ext_en_req ? I_BLOCK_EN : 1'b1;
   assign sa_rise = I_SAFETY_ACT & ~sa_prev;
   assign re_rise = I_RESTART_RST & ~re_prev;
   assign re_fall = ~I_RESTART_RST & re_prev;
   assign sync_fault = first_edge & edge_a & edge_b;
   assign rate_diff = (rate_a > rate_b) ? rate_a - rate_b : rate_b - rate_a;
   assign hyst_lhs = {6'h00, rate_a} * `HYST_DEN;
   assign hyst_rhs = {16'h0000, threshold} * `HYST_NUM;

   // Fault found at end of a gate, 0 when none
   always @* begin
      gate_err = 16'h0000;
      if (rate_a > `RANGE_MAX_HZ || rate_b > `RANGE_MAX_HZ) begin
         gate_err = `DG_ERR_RANGE;
      end else if (rate_a == 16'h0000 && rate_b == 16'h0000) begin
         if (first_edge && !level_a && !level_b) begin
            gate_err = `DG_ERR_OPEN;
         end
      end else if (rate_a == 16'h0000 || rate_b == 16'h0000) begin
         gate_err = `DG_ERR_NOPULSE;
      end else if (rate_diff > `DIFF_TOL_HZ) begin
         gate_err = `DG_ERR_DIFF;
      end
   end

   // Standstill with hysteresis once tripped
   always @* begin
      if (tripped) begin
         still_ok = hyst_lhs <= hyst_rhs;
      end else begin
         still_ok = rate_a <= {10'h000, threshold};
      end
   end

   // ==========================================================================
   // Restart state machine
   always @* begin
      next_state = state;
      next_err_code = err_code;
      next_tripped = tripped;
      case (state)
         ST_IDLE: begin
            if (active) begin
               next_state = ST_WAIT_SA;
            end
         end
         ST_WAIT_SA: begin
            if (sa_rise) begin
               if (mode == `MODE_AUTO) begin
                  next_state = ST_MEASURE;
               end else if (I_RESTART_RST) begin
                  next_state = ST_FAULT;
                  next_err_code = `DG_ERR_RESET;
               end else begin
                  next_state = ST_RE_RISE;
               end
            end
         end
         ST_RE_RISE: begin
            if (re_rise) begin
               next_state = ST_RE_FALL;
            end
         end
         ST_RE_FALL: begin
            if (re_fall) begin
               next_state = ST_MEASURE;
            end
         end
         ST_MEASURE: begin
            if (mode == `MODE_AUTO && !first_edge && !tripped) begin
               next_state = ST_STILL;
            end else if (gate_d && gate_err == 16'h0000 && still_ok) begin
               next_state = ST_STILL;
               next_tripped = 1'b0;
            end
         end
         ST_STILL: begin
            if (gate_d && rate_a > {10'h000, threshold}) begin
               next_tripped = 1'b1;
               if (mode == `MODE_AUTO) begin
                  next_state = ST_MEASURE;
               end else begin
                  next_state = ST_RE_RISE;
               end
            end
         end
         ST_FAULT: begin
            if (!I_SAFETY_ACT) begin
               next_state = ST_WAIT_SA;
               next_err_code = 16'h0000;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Running faults override every monitoring state
      if (state != ST_FAULT && state != ST_IDLE && state != ST_WAIT_SA) begin
         if (sync_fault) begin
            next_state = ST_FAULT;
            next_err_code = `DG_ERR_DIFF;
         end else if (gate_d && gate_err != 16'h0000) begin
            next_state = ST_FAULT;
            next_err_code = gate_err;
         end
      end
      if (state != ST_FAULT) begin
         if (!active) begin
            next_state = ST_IDLE;
         end else if (!I_SAFETY_ACT && state != ST_IDLE) begin
            next_state = ST_WAIT_SA;
         end
      end
   end

   always @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state <= ST_IDLE;
         err_code <= 16'h0000;
         tripped <= 1'b0;
         first_edge <= 1'b0;
         gate_d <= 1'b0;
         sa_prev <= 1'b0;
         re_prev <= 1'b0;
      end else begin
         state <= next_state;
         err_code <= next_err_code;
         tripped <= next_tripped;
         gate_d <= gate;
         sa_prev <= I_SAFETY_ACT;
         re_prev <= I_RESTART_RST;
         if (rise_a || rise_b) begin
            first_edge <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Contact and value outputs
   always @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_STANDSTILL <= 1'b0;
         O_FAULT <= 1'b0;
         O_FREQ <= 16'h0000;
         O_DIAG <= `DG_NO_ENABLE;
      end else begin
         O_STANDSTILL <= (next_state == ST_STILL);
         O_FAULT <= (next_state == ST_FAULT);
         O_FREQ <= rate_a;
         case (next_state)
            ST_IDLE: O_DIAG <= `DG_NO_ENABLE;
            ST_WAIT_SA: O_DIAG <= `DG_WAIT_SA;
            ST_RE_RISE: O_DIAG <= `DG_WAIT_RE_RISE;
            ST_RE_FALL: O_DIAG <= `DG_WAIT_RE_FALL;
            ST_MEASURE: O_DIAG <= `DG_MEASURING;
            ST_STILL: O_DIAG <= `DG_STANDSTILL;
            ST_FAULT: O_DIAG <= next_err_code;
            default: O_DIAG <= `DG_NO_ENABLE;
         endcase
      end
   end

   // ==========================================================================
   // APB slave
   assign apb_setup = I_PSEL & ~I_PENABLE;
   assign apb_write = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

   // Threshold writes are clamped into the legal range
   always @* begin
      wr_thr = I_PWDATA[`CFG_THR_MSB:`CFG_THR_LSB];
      if (wr_thr < `THR_MIN) begin
         wr_thr = `THR_MIN;
      end else if (wr_thr > `THR_MAX) begin
         wr_thr = `THR_MAX;
      end
   end

   always @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ext_en_req <= `CFG_EXT_EN_RST;
         mode <= `CFG_MODE_RST;
         threshold <= `CFG_THR_RST;
      end else if (apb_write && I_PADDR == `REG_CFG) begin
         ext_en_req <= I_PWDATA[`CFG_EXT_EN_BIT];
         if (I_PWDATA[`CFG_MODE_MSB:`CFG_MODE_LSB] != 2'h3) begin
            mode <= I_PWDATA[`CFG_MODE_MSB:`CFG_MODE_LSB];
         end
         threshold <= wr_thr;
      end
   end

   always @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= apb_setup;
         O_PSLVERR <= 1'b0;
         O_PRDATA <= 32'h00000000;
         if (apb_setup) begin
            case (I_PADDR)
               `REG_CFG: begin
                  O_PRDATA <= {18'h00000, threshold, 5'h00, mode,
                     ext_en_req};
               end
               `REG_STATUS: begin
                  O_PRDATA <= {13'h0000, first_edge, O_FAULT,
                     O_STANDSTILL, O_DIAG};
               end
               `REG_FREQ: O_PRDATA <= {16'h0000, O_FREQ};
               default: O_PSLVERR <= 1'b1;
            endcase
         end
      end
   end
endmodule

// ---- hw/standstill_regs.vh ----
// Register map, field layout, codes and timing for the standstill monitor
`ifndef STANDSTILL_REGS_VH
`define STANDSTILL_REGS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define REG_CFG 12'h000
`define REG_STATUS 12'h004
`define REG_FREQ 12'h008

// ==========================================================================
// Configuration fields
`define CFG_EXT_EN_BIT 0
`define CFG_MODE_LSB 1
`define CFG_MODE_MSB 2
`define CFG_THR_LSB 8
`define CFG_THR_MSB 13
`define CFG_EXT_EN_RST 1'b0
`define CFG_MODE_RST 2'h1
`define CFG_THR_RST 6'h02
`define THR_MIN 6'h02
`define THR_MAX 6'h32

// Restart modes
`define MODE_AUTO 2'h0
`define MODE_MANUAL 2'h1
`define MODE_CONTROLLED 2'h2

// Status fields
`define STAT_STILL_BIT 16
`define STAT_FAULT_BIT 17
`define STAT_EDGE_BIT 18

// ==========================================================================
// Diagnostic codes
`define DG_NO_ENABLE 16'h0000
`define DG_WAIT_SA 16'h2001
`define DG_WAIT_RE_RISE 16'h2003
`define DG_WAIT_RE_FALL 16'h2004
`define DG_MEASURING 16'h2009
`define DG_STANDSTILL 16'h8010
`define DG_ERR_OPEN 16'hf007
`define DG_ERR_RANGE 16'hf008
`define DG_ERR_DIFF 16'hf009
`define DG_ERR_NOPULSE 16'hf00a
`define DG_ERR_RESET 16'hf013

// ==========================================================================
// Measurement limits and timing
`define RANGE_MAX_HZ 16'h04b0
`define DIFF_TOL_HZ 16'h0001
`define HYST_NUM 22'h000013
`define HYST_DEN 22'h000014
`define GATE_MS 1000
`define CLK_KHZ 200000
`define GATE_CYCLES (`GATE_MS * `CLK_KHZ)

`endif

// ---- tb/sensor_wheel.sv ----
// Behavioural pair of proximity sensors over a rotating cam wheel
`timescale 1ns/1ps
module sensor_wheel (
   input wire logic i_clk, // Clock
   input wire logic [2:0] i_mode, // 0 high,1 low,2 turn,3 in step,4 one dead
   input wire logic [7:0] i_period, // Cycles per cam, 8 or more
   output logic o_a, // First sensor level
   output logic o_b // Second sensor level
);
   logic [7:0] ph = 8'h00;
   logic a_on;
   logic b_on;
   // Cams cover three quarters, half a cam apart: one sensor always on
   assign a_on = ph >= {2'h0, i_period[7:2]};
   assign b_on = ph < {1'h0, i_period[7:1]} ||
      ph >= i_period - {2'h0, i_period[7:2]};
   initial {o_a, o_b} = 2'b11;
   // A period of eight cycles or more keeps the rate far below the range
   always @(posedge i_clk) begin
      ph <= (ph >= i_period - 8'h01) ? 8'h00 : ph + 8'h01;
      case (i_mode)
         3'h0: {o_a, o_b} <= 2'b11;
         3'h1: {o_a, o_b} <= 2'b00;
         3'h2: {o_a, o_b} <= {a_on, b_on};
         3'h3: {o_a, o_b} <= {a_on, a_on};
         default: {o_a, o_b} <= {a_on, 1'b1};
      endcase
   end
endmodule

// ---- tb/standstill_monitor_block_assertions.sv ----
// Port-level checks for the standstill monitor
`timescale 1ns/1ps
module standstill_checker (
   input wire I_CLK, // Clock
   input wire I_SYS_RST, // Reset
   input wire I_SAFETY_ACT, // Activation
   input wire I_RESTART_RST, // Restart reset
   input wire I_BLOCK_EN, // Enable
   input wire I_PSEL, // Select
   input wire I_PENABLE, // Access
   input wire [11:0] I_PADDR, // Address
   input wire O_PREADY, // Ready
   input wire [31:0] O_PRDATA, // Read data
   input wire O_PSLVERR, // Bus error
   input wire O_STANDSTILL, // Standstill
   input wire O_FAULT, // Fault
   input wire [15:0] O_DIAG // Diagnostic
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   // ==========================================================
   // Assertions
   a_ready_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("No ready after setup");
   a_err_unmapped: assert property (O_PREADY && I_PADDR > 12'h008
      |-> O_PSLVERR && O_PRDATA == 32'h0) else $error("Bad unmapped");
   a_still_code: assert property (
      O_STANDSTILL |-> O_DIAG == 16'h8010) else $error("Still code");
   a_fault_code: assert property (
      O_FAULT |-> O_DIAG[15:12] == 4'hf && !O_STANDSTILL)
      else $error("Fault code");
   a_sa_drop: assert property (
      (!I_SAFETY_ACT) [*2] |-> !O_STANDSTILL && !O_FAULT)
      else $error("Active after drop");
   a_reset_early: assert property (
      I_RESTART_RST && I_BLOCK_EN && $rose(I_SAFETY_ACT) &&
      O_DIAG == 16'h2001 |=> O_DIAG == 16'hf013 || O_DIAG == 16'h2009)
      else $error("Reset at start");
   a_re_rise: assert property (
      O_DIAG == 16'h2003 && $rose(I_RESTART_RST) && I_SAFETY_ACT &&
      I_BLOCK_EN |=> O_DIAG == 16'h2004 || O_DIAG[15:12] == 4'hf)
      else $error("No wait for fall");
   a_re_fall: assert property (
      O_DIAG == 16'h2004 && $fell(I_RESTART_RST) && I_SAFETY_ACT &&
      I_BLOCK_EN |=> O_DIAG == 16'h2009 || O_DIAG[15:12] == 4'hf)
      else $error("No start after fall");
   c_still: cover property (O_STANDSTILL);
   c_early: cover property (O_DIAG == 16'hf013);
   c_sync: cover property (O_DIAG == 16'hf009);
endmodule

bind standstill_monitor_block standstill_checker i_standstill_checker (
   .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_SAFETY_ACT(I_SAFETY_ACT),
   .I_RESTART_RST(I_RESTART_RST), .I_BLOCK_EN(I_BLOCK_EN),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR),
   .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
   .O_STANDSTILL(O_STANDSTILL), .O_FAULT(O_FAULT), .O_DIAG(O_DIAG));

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual-sensor standstill monitor
`timescale 1ns/1ps
module tb_top;
   localparam int GATE = 200;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sa = 1'b0;
   logic re = 1'b0;
   logic en = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] wmode = 3'h0;
   logic [7:0] wper = 8'h14;
   logic s_a, s_b, pready, pslverr, still, fault, er;
   logic [31:0] prdata, rd;
   logic [15:0] freq, diag;
   int n_errors = 0;
   int cmp_count = 0;
   integer seed = 60;
   int p, t, r;

   always #2.5 clk = ~clk;

   sensor_wheel i_sensor_wheel (.i_clk(clk), .i_mode(wmode),
      .i_period(wper), .o_a(s_a), .o_b(s_b));
   standstill_monitor_block #(.GATE_CYCLES(GATE))
      i_standstill_monitor_block (
      .I_CLK(clk), .I_SYS_RST(rst), .I_SENSOR_A(s_a), .I_SENSOR_B(s_b),
      .I_SAFETY_ACT(sa), .I_RESTART_RST(re), .I_BLOCK_EN(en),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
      .O_PSLVERR(pslverr), .O_STANDSTILL(still), .O_FAULT(fault),
      .O_FREQ(freq), .O_DIAG(diag));

   // ==========================================================
   // Helpers
   function automatic int clamp(input int th);
      return (th < 2) ? 2 : (th > 50) ? 50 : th;
   endfunction
   function automatic logic [31:0] cfg(input logic x, input logic [1:0] m,
      input int th);
      return {18'h0, th[5:0], 5'h0, m, x};
   endfunction
   task automatic report_and_stop;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({31'h0, pready}, 32'h1);
      if (pready !== 1'b1) begin
         report_and_stop;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_diag(input logic [15:0] c, input int lim);
      int n;
      n = 0;
      while (diag !== c && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk({16'h0, diag}, {16'h0, c});
      if (diag !== c) begin
         report_and_stop;
      end
   endtask
   task automatic restart;
      re <= 1'b1;
      wait_diag(16'h2004, 4);
      re <= 1'b0;
      wait_diag(16'h2009, 4);
   endtask
   task automatic sa_cycle(input logic [2:0] m);
      sa <= 1'b0;
      wmode <= m;
      wait_diag(16'h2001, 4);
      repeat (GATE) @(posedge clk);
      sa <= 1'b1;
      @(posedge clk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, cfg(1'b0, 2'h1, 2));
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h00002001);
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      for (int i = 0; i < 6; i++) begin
         t = (i == 0) ? 1 : (i == 1) ? 60 : 2 + {$random(seed)} % 49;
         apb(1'b1, 12'h000, cfg(1'b0, 2'h1, t));
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, cfg(1'b0, 2'h1, clamp(t)));
      end
      apb(1'b1, 12'h000, cfg(1'b0, 2'h3, 2));
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, cfg(1'b0, 2'h1, 2));
      re <= 1'b1;
      @(posedge clk);
      sa <= 1'b1;
      wait_diag(16'hf013, 4);
      chk({31'h0, fault}, 32'h1);
      re <= 1'b0;
      sa_cycle(3'h0);
      wait_diag(16'h2003, 4);
      restart;
      wait_diag(16'h8010, 2 * GATE + 9);
      chk({31'h0, still}, 32'h1);
      wmode <= 3'h2;
      wait_diag(16'h2003, 2 * GATE + 9);
      repeat (GATE + GATE / 2) @(posedge clk);
      chk({16'h0, freq}, GATE / 20);
      wmode <= 3'h0;
      repeat (2 * GATE) @(posedge clk);
      chk({16'h0, diag}, 32'h2003);
      restart;
      wait_diag(16'h8010, 2 * GATE + 9);
      apb(1'b1, 12'h000, cfg(1'b0, 2'h0, 2));
      sa_cycle(3'h0);
      wait_diag(16'h8010, 2 * GATE + 9);
      repeat (GATE / 2) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         p = 8 + {$random(seed)} % 60;
         t = 2 + {$random(seed)} % 24;
         r = GATE / p;
         apb(1'b1, 12'h000, cfg(1'b0, 2'h0, t));
         wper <= p[7:0];
         wmode <= 3'h2;
         repeat (3 * GATE - 3) @(posedge clk);
         if (r > t + 1 || r + 2 < t) chk(still, r <= t);
         wmode <= 3'h0;
         repeat (2 * GATE) @(posedge clk);
         chk({16'h0, diag}, 32'h8010);
      end
      wper <= 8'h14;
      wmode <= 3'h3;
      wait_diag(16'hf009, 99);
      chk({31'h0, still}, 32'h0);
      sa_cycle(3'h4);
      wait_diag(16'hf00a, 3 * GATE);
      sa_cycle(3'h1);
      wait_diag(16'hf007, 3 * GATE);
      sa <= 1'b0;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b1, 12'h000, cfg(1'b0, 2'h0, 2));
      sa <= 1'b1;
      wait_diag(16'h8010, 9);
      en <= 1'b0;
      apb(1'b1, 12'h000, cfg(1'b1, 2'h0, 2));
      wait_diag(16'h0000, 4);
      en <= 1'b1;
      sa <= 1'b0;
      wait_diag(16'h2001, 4);
      sa <= 1'b1;
      wait_diag(16'h8010, 9);
      report_and_stop;
   end
endmodule
